// File: logic/lfs_pkg.sv
package lfs_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // command codes of the serial register map
  localparam logic [7:0]  CMD_BIAS_LIMIT   = 8'h11;
  localparam logic [7:0]  CMD_FAULT_STATUS = 8'h12;
  // serial slave address, arbitrary value
  localparam logic [6:0]  DEV_ADDR         = 7'h2A;

  ////////////////////////////////////////////////////////////////////////////
  // fault status field positions
  localparam int unsigned BIT_READY   = 10;
  localparam int unsigned BIT_TX_EN   = 9;
  localparam int unsigned BIT_EN_PIN  = 8;
  localparam int unsigned BIT_TWICE   = 7;
  localparam int unsigned BIT_ONCE    = 6;
  localparam int unsigned BIT_FAULTED = 5;
  localparam int unsigned COR_W       = 5;
  localparam int unsigned BIAS_W      = 7;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] STATUS_RESET     = 16'h0070;
  localparam logic [4:0]  COR_RESET        = 5'h10;
  localparam logic [6:0]  BIAS_LIMIT_RESET = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // repeat-fault window timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned WINDOW_MS     = 25;
  localparam int unsigned WINDOW_CYCLES = WINDOW_MS * (CLK_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////////
  // serial slave states, gray along the write path
  typedef enum logic [2:0] {
    LFS_IDLE = 3'b000,
    LFS_ADDR = 3'b001,
    LFS_CMD  = 3'b011,
    LFS_WR   = 3'b010,
    LFS_RD   = 3'b110
  } lfs_state_t;
endpackage : lfs_pkg

// File: logic/lfs_sync.sv
`timescale 1ns/1ps
module lfs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock
  input  wire logic             ref_clk_in,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] async_in,
  // synchronised levels
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // two-stage synchroniser, no reset so pin levels show from power-on
  always_ff @(posedge ref_clk_in) begin
    meta_ff  <= async_in;
    sync_out <= meta_ff;
  end
endmodule : lfs_sync

// File: logic/lfs_supervisor.sv
// What this block does
// - ready bit on settled currents, fault clears
// - enabled bit needs pin, soft enable, no fault
// - bit 8 mirrors synchronised enable pin
// - second fault in window locks out forever
// - first-fault flag set when transmitter disabled
// - quiet window after re-enable clears first-fault
// - any fault sets faulted bit
// - undervoltage set at power-up, clears on full status read
// - failed memory load sets bit 3
// - overpower only in closed loop, when enabled
// - underpower only in closed loop, when enabled
// - bias above limit sets overcurrent when enabled
// - auto shutdown stops laser on fault
// - bias limit is seven-bit own register
// - enable bits gate fault recording
`timescale 1ns/1ps
module lfs_supervisor #(
  parameter int unsigned WINDOW_CYCLES = lfs_pkg::WINDOW_CYCLES,
  parameter logic [6:0]  DEV_ADDR      = lfs_pkg::DEV_ADDR
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // enable pin and configuration
  input  wire logic        en_pin_in,
  input  wire logic        soft_en_in,
  input  wire logic        auto_shutdn_en_in,
  input  wire logic        rep_flt_inhibit_in,
  input  wire logic        closed_loop_power_mode_in,
  input  wire logic        over_pwr_en_in,
  input  wire logic        under_pwr_en_in,
  input  wire logic        over_current_en_in,
  // fault sources
  input  wire logic        uv_event_in,
  input  wire logic        mem_load_fail_in,
  input  wire logic        md_over_in,
  input  wire logic        md_under_in,
  input  wire logic [6:0]  bias_current_in,
  input  wire logic        currents_settled_in,
  // transmitter control and status
  output logic             tx_drive_out,
  output logic [15:0]      status_out
);
  localparam int unsigned WIN_W = $clog2(WINDOW_CYCLES + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  logic [2:0] pins_s;
  logic       scl_s, sda_s, en_s, scl_q_ff, sda_q_ff;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  lfs_sync #(.WIDTH(3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .async_in   ({en_pin_in, sda_in, scl_in}),
    .sync_out   (pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign en_s  = pins_s[2];

  // previous bus levels
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end
  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign sda_out   = 1'b0; // open drain, only pulls low

  // bit of a word sent on the bus, low byte first, msb first
  function automatic logic word_bit(input logic [15:0] w, input logic idx, input logic [3:0] cnt);
    word_bit = w[{idx, 3'd7 - cnt[2:0]}];
  endfunction : word_bit

  ////////////////////////////////////////////////////////////////////////////
  // fault supervision state
  logic [15:0]      status_ff, nxt_status;
  logic [4:0]       cor_ff, nxt_cor, cor_clr, set_vec;
  logic             faulted_ff, nxt_faulted, once_ff, nxt_once, twice_ff, nxt_twice;
  logic             win_act_ff, nxt_win_act, tx_req_q_ff, tx_drive_ff, nxt_drive;
  logic [WIN_W-1:0] win_cnt_ff, nxt_win_cnt;
  logic [6:0]       limit_ff, nxt_limit;
  logic             tx_req, fault_evt, nxt_txen, nxt_ready;

  // fault detection, faulted state, lockout window
  always_comb begin
    tx_req     = en_s & soft_en_in;
    set_vec[4] = uv_event_in;
    set_vec[3] = mem_load_fail_in;
    set_vec[2] = closed_loop_power_mode_in & over_pwr_en_in & md_over_in;
    set_vec[1] = closed_loop_power_mode_in & under_pwr_en_in & md_under_in;
    set_vec[0] = over_current_en_in & (bias_current_in > limit_ff);
    fault_evt  = |set_vec;
    nxt_cor     = (cor_ff & ~cor_clr) | set_vec;
    nxt_faulted = fault_evt ? 1'b1 : (tx_req ? faulted_ff : 1'b0);
    nxt_once    = once_ff;
    nxt_twice   = twice_ff;
    nxt_win_act = win_act_ff;
    nxt_win_cnt = win_cnt_ff;
    if (rep_flt_inhibit_in && faulted_ff && !tx_req) begin
      nxt_once = 1'b1;
    end
    if (tx_req && !tx_req_q_ff && once_ff) begin
      nxt_win_act = rep_flt_inhibit_in;
      nxt_win_cnt = '0;
      nxt_once    = rep_flt_inhibit_in;
    end else if (win_act_ff) begin
      if (!tx_req) begin
        nxt_win_act = 1'b0;
      end else if (fault_evt) begin
        nxt_twice   = 1'b1;
        nxt_win_act = 1'b0;
      end else if (win_cnt_ff == WIN_LAST) begin
        nxt_once    = 1'b0;
        nxt_win_act = 1'b0;
      end else begin
        nxt_win_cnt = win_cnt_ff + 1'b1;
      end
    end
    nxt_drive = tx_req & ~twice_ff & ~nxt_twice & ~(auto_shutdn_en_in & nxt_faulted);
    nxt_txen  = tx_req & ~nxt_faulted & ~nxt_twice;
    nxt_ready = currents_settled_in & nxt_txen;
    nxt_status              = '0;
    nxt_status[4:0]         = nxt_cor;
    nxt_status[lfs_pkg::BIT_FAULTED] = nxt_faulted;
    nxt_status[lfs_pkg::BIT_ONCE]    = nxt_once;
    nxt_status[lfs_pkg::BIT_TWICE]   = nxt_twice;
    nxt_status[lfs_pkg::BIT_EN_PIN]  = en_s;
    nxt_status[lfs_pkg::BIT_TX_EN]   = nxt_txen;
    nxt_status[lfs_pkg::BIT_READY]   = nxt_ready;
  end

  // fault supervision registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      status_ff   <= lfs_pkg::STATUS_RESET;
      cor_ff      <= lfs_pkg::COR_RESET;
      faulted_ff  <= 1'b1;
      once_ff     <= 1'b1;
      twice_ff    <= 1'b0;
      win_act_ff  <= 1'b0;
      win_cnt_ff  <= '0;
      tx_req_q_ff <= 1'b0;
      tx_drive_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      cor_ff      <= nxt_cor;
      faulted_ff  <= nxt_faulted;
      once_ff     <= nxt_once;
      twice_ff    <= nxt_twice;
      win_act_ff  <= nxt_win_act;
      win_cnt_ff  <= nxt_win_cnt;
      tx_req_q_ff <= tx_req;
      tx_drive_ff <= nxt_drive;
    end
  end
  assign tx_drive_out = tx_drive_ff;
  assign status_out   = {status_ff[15:9], en_s, status_ff[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // serial register slave
  lfs_pkg::lfs_state_t state_ff, nxt_state;
  logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [7:0]  shift_ff, nxt_shift, cmd_ff, nxt_cmd, lo_ff, nxt_lo;
  logic [15:0] tx_ff, nxt_tx;
  logic [4:0]  snap_ff, nxt_snap;
  logic        ack_ff, nxt_ack, idx_ff, nxt_idx, nack_ff, nxt_nack, sda_oe_ff, nxt_oe;

  // byte framing, acknowledge, word read and write
  always_comb begin
    nxt_state = state_ff;  nxt_bit_cnt = bit_cnt_ff; nxt_shift = shift_ff;
    nxt_cmd   = cmd_ff;    nxt_lo      = lo_ff;      nxt_tx    = tx_ff;
    nxt_snap  = snap_ff & ~set_vec; // fresh events drop out of the pending clear
    nxt_ack     = ack_ff;     nxt_idx   = idx_ff;
    nxt_nack  = nack_ff;   nxt_oe      = sda_oe_ff;  nxt_limit = limit_ff;
    cor_clr   = '0;
    if (bus_start) begin
      nxt_state = lfs_pkg::LFS_ADDR;
      nxt_bit_cnt = '0;
      nxt_ack = 1'b0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = lfs_pkg::LFS_IDLE;
      nxt_ack = 1'b0;
      nxt_oe = 1'b0;
    end else if (state_ff != lfs_pkg::LFS_IDLE) begin
      if (scl_rise) begin
        if (!ack_ff) begin
          nxt_shift   = {shift_ff[6:0], sda_s};
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
        end else begin
          nxt_nack = sda_s; // master acknowledge of a read byte
        end
      end else if (scl_fall) begin
        if (!ack_ff && bit_cnt_ff == 4'h8) begin
          nxt_ack = 1'b1;
          if (state_ff == lfs_pkg::LFS_ADDR) begin
            nxt_oe = (shift_ff[7:1] == DEV_ADDR);
          end else begin
            nxt_oe = (state_ff != lfs_pkg::LFS_RD);
          end
        end else if (ack_ff) begin
          nxt_ack = 1'b0;
          nxt_bit_cnt = '0;
          nxt_oe = 1'b0;
          case (state_ff)
            lfs_pkg::LFS_ADDR: begin
              nxt_idx = 1'b0;
              if (shift_ff[7:1] != DEV_ADDR) begin
                nxt_state = lfs_pkg::LFS_IDLE;
              end else if (shift_ff[0]) begin
                nxt_state = lfs_pkg::LFS_RD;
                nxt_snap  = status_ff[4:0] & ~set_vec;
                if (cmd_ff == lfs_pkg::CMD_FAULT_STATUS) begin
                  nxt_tx = status_ff;
                end else if (cmd_ff == lfs_pkg::CMD_BIAS_LIMIT) begin
                  nxt_tx = {9'h000, limit_ff};
                end else begin
                  nxt_tx = 16'h0000;
                end
              end else begin
                nxt_state = lfs_pkg::LFS_CMD;
              end
            end
            lfs_pkg::LFS_CMD: begin
              nxt_cmd = shift_ff;
              nxt_state = lfs_pkg::LFS_WR;
              nxt_idx = 1'b0;
            end
            lfs_pkg::LFS_WR: begin
              if (!idx_ff) begin
                nxt_lo = shift_ff;
                nxt_idx = 1'b1;
              end else begin
                if (cmd_ff == lfs_pkg::CMD_BIAS_LIMIT) begin
                  nxt_limit = lo_ff[6:0];
                end
                nxt_state = lfs_pkg::LFS_IDLE;
              end
            end
            lfs_pkg::LFS_RD: begin
              if (nack_ff || idx_ff) begin
                nxt_state = lfs_pkg::LFS_IDLE;
                if (idx_ff && cmd_ff == lfs_pkg::CMD_FAULT_STATUS) begin
                  cor_clr = snap_ff;
                end
              end else begin
                nxt_idx = 1'b1;
              end
            end
            default: nxt_state = lfs_pkg::LFS_IDLE;
          endcase
          if (nxt_state == lfs_pkg::LFS_RD) begin
            nxt_oe = ~word_bit(nxt_tx, nxt_idx, 4'h0);
          end
        end else if (state_ff == lfs_pkg::LFS_RD) begin
          nxt_oe = ~word_bit(tx_ff, idx_ff, bit_cnt_ff);
        end
      end
    end
  end

  // serial slave registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_ff <= lfs_pkg::LFS_IDLE; bit_cnt_ff <= '0; shift_ff <= '0;
      cmd_ff   <= '0; lo_ff <= '0; tx_ff <= '0; snap_ff <= '0;
      ack_ff   <= 1'b0; idx_ff <= 1'b0; nack_ff <= 1'b0; sda_oe_ff <= 1'b0;
      limit_ff <= lfs_pkg::BIAS_LIMIT_RESET;
    end else begin
      state_ff <= nxt_state; bit_cnt_ff <= nxt_bit_cnt; shift_ff <= nxt_shift;
      cmd_ff   <= nxt_cmd; lo_ff <= nxt_lo; tx_ff <= nxt_tx; snap_ff <= nxt_snap;
      ack_ff   <= nxt_ack; idx_ff <= nxt_idx; nack_ff <= nxt_nack; sda_oe_ff <= nxt_oe;
      limit_ff <= nxt_limit;
    end
  end
  assign sda_oe_out = sda_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_quiet_reenable;
    win_act_ff && tx_req && !fault_evt && win_cnt_ff == WIN_LAST;
  endsequence

  a_ready_on_fault: assert property (fault_evt |=> !status_ff[lfs_pkg::BIT_READY])
    else $error("ready bit survived a fault");
  a_txen_needs_req: assert property (status_ff[lfs_pkg::BIT_TX_EN] |-> $past(tx_req) && !faulted_ff)
    else $error("enabled bit without request or with fault");
  a_twice_locks: assert property (twice_ff |=> twice_ff && !tx_drive_ff)
    else $error("lockout released or laser driven");
  a_once_on_off: assert property (rep_flt_inhibit_in && faulted_ff && !tx_req
                                  |=> status_ff[lfs_pkg::BIT_ONCE])
    else $error("first-fault flag not set at disable");
  a_window_clear: assert property (s_quiet_reenable |=> !once_ff ##0 !win_act_ff)
    else $error("first-fault flag kept after quiet window");
  a_fault_sets: assert property (fault_evt
                                 |=> status_ff[lfs_pkg::BIT_FAULTED] && status_ff[4:0] != 5'h00)
    else $error("fault not recorded");
  a_auto_shut: assert property (auto_shutdn_en_in && fault_evt |=> !tx_drive_ff)
    else $error("laser still driven under auto shutdown");
  a_oc_detect: assert property (over_current_en_in && bias_current_in > limit_ff |=> status_ff[0])
    else $error("overcurrent not flagged");
  a_op_gate: assert property (!closed_loop_power_mode_in && !$past(status_ff[2]) && !status_ff[2]
                              |=> !status_ff[2] || $past(closed_loop_power_mode_in))
    else $error("overpower outside closed loop");
  a_set_wins: assert property (|set_vec |=> (status_ff[4:0] & $past(set_vec)) == $past(set_vec))
    else $error("event lost during read clear");
  a_reserved_zero: assert property (status_ff[15:11] == 5'h00)
    else $error("reserved bits not zero");
endmodule : lfs_supervisor

// File: verif/lfs_host.sv
`timescale 1ns/1ps
module lfs_host (
  // clock the host paces itself by
  input  wire logic ref_clk_in,
  // resolved data line
  input  wire logic sda_in,
  // host line drives, high means released to the pull-up
  output logic      scl_out,
  output logic      sda_out
);
  ////////////////////////////////////////////////////////////////////////////
  // idle bus: both lines released, clock stands still between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // quarter of the 160 ns bus period, moves on falling edges only
  task automatic qtr();
    repeat (4) @(negedge ref_clk_in);
  endtask : qtr

  // one bit slot, data set in the low phase, line sampled mid-high
  task automatic bit_slot(input logic b, output logic r);
    sda_out = b;
    qtr();
    scl_out = 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl_out = 1'b0;
    qtr();
  endtask : bit_slot

  // start or repeated start, releases data first, then pulls it low while the clock is high
  task automatic start();
    sda_out = 1'b1;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_out = 1'b0;
    qtr();
    scl_out = 1'b0;
    qtr();
  endtask : start

  // stop condition, leaves the bus idle
  task automatic stop();
    sda_out = 1'b0;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_out = 1'b1;
    qtr();
  endtask : stop

  // byte out msb first, then the ack slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // byte in msb first, last = 1 answers with a nack
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(last, r);
  endtask : recv_byte

  // word write, low byte first
  task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data,
                            output logic ok);
    logic a0, a1, a2, a3;
    start();
    send_byte({addr, 1'b0}, a0);
    send_byte(cmd, a1);
    send_byte(data[7:0], a2);
    send_byte(data[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : write_word

  // word read; full = 0 stops after the low byte with a nack
  task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd, input logic full,
                           output logic [15:0] data, output logic ok);
    logic       a0, a1, a2;
    logic [7:0] lo;
    logic [7:0] hi;
    hi = 8'h00;
    start();
    send_byte({addr, 1'b0}, a0);
    send_byte(cmd, a1);
    start();
    send_byte({addr, 1'b1}, a2);
    recv_byte(~full, lo);
    if (full) begin
      recv_byte(1'b1, hi);
    end
    stop();
    data = {hi, lo};
    ok = a0 & a1 & a2;
  endtask : read_word
endmodule : lfs_host

// File: verif/laser_fault_status_supervisor_tb_top.sv
`timescale 1ns/1ps
module laser_fault_status_supervisor_tb_top;
  ////////////////////////////////////////////////////////////////////////////
  // short repeat-fault window for simulation
  localparam int unsigned WIN = 50;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        en_pin = 1'b0, soft_en = 1'b1, auto_sd = 1'b1, rep = 1'b1, clm = 1'b1;
  logic        op_en = 1'b1, up_en = 1'b1, oc_en = 1'b1, settled = 1'b1;
  logic        uv = 1'b0, mem_fail = 1'b0, md_over = 1'b0, md_under = 1'b0;
  logic [6:0]  bias = 7'h00;
  logic        scl, host_sda, sda_dut, sda_oe, tx_drive, ok;
  logic [15:0] status, rd, b;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  wire         sda_w;

  // open-drain data line with pull-up
  assign sda_w = host_sda & ~(sda_oe & ~sda_dut);
  always #5 ref_clk_in = ~ref_clk_in;

  lfs_supervisor #(.WINDOW_CYCLES(WIN)) u_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_dut), .sda_oe_out(sda_oe), .en_pin_in(en_pin), .soft_en_in(soft_en),
    .auto_shutdn_en_in(auto_sd), .rep_flt_inhibit_in(rep), .closed_loop_power_mode_in(clm),
    .over_pwr_en_in(op_en), .under_pwr_en_in(up_en), .over_current_en_in(oc_en),
    .uv_event_in(uv), .mem_load_fail_in(mem_fail), .md_over_in(md_over), .md_under_in(md_under),
    .bias_current_in(bias), .currents_settled_in(settled), .tx_drive_out(tx_drive),
    .status_out(status));

  lfs_host u_host (.ref_clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(host_sda));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc

  // one-cycle fault on source i (0 bias, 1 under, 2 over, 3 memory, 4 supply)
  task automatic pulse(input int i);
    case (i)
      0: bias = 7'h41;
      1: md_under = 1'b1;
      2: md_over = 1'b1;
      3: mem_fail = 1'b1;
      default: uv = 1'b1;
    endcase
    cyc(1);
    bias = 7'h00;
    md_under = 1'b0;
    md_over = 1'b0;
    mem_fail = 1'b0;
    uv = 1'b0;
  endtask : pulse

  // drop and restore the soft enable to leave the faulted state
  task automatic toggle_en();
    soft_en = 1'b0;
    cyc(3);
    soft_en = 1'b1;
    cyc(5);
  endtask : toggle_en

  task automatic rd_status(input logic full);
    u_host.read_word(lfs_pkg::DEV_ADDR, lfs_pkg::CMD_FAULT_STATUS, full, rd, ok);
    cyc(3);
  endtask : rd_status

  task automatic tdone(input string name);
    $display("test %s done: %0d checks, %0d mismatches", name, checks_done, n_mismatch);
  endtask : tdone

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    cyc(2);
    chk(status, 16'h0070, "reset value");
    chk(16'(tx_drive), 16'h0000, "drive in reset");
    rst_n_in = 1'b1;
    cyc(10);
    chk(status, 16'h0050, "after release");
    rd_status(1'b1);
    chk(rd, 16'h0050, "power-up read");
    chk(status, 16'h0040, "supply flag cleared");
    tdone("power-up");
    en_pin = 1'b1;
    cyc(20);
    chk(status, 16'h0740, "inside window");
    cyc(WIN);
    chk(status, 16'h0700, "window expired");
    chk(16'(tx_drive), 16'h0001, "drive on");
    settled = 1'b0;
    cyc(3);
    chk(status, 16'h0300, "not settled");
    settled = 1'b1;
    tdone("enable");
    u_host.write_word(lfs_pkg::DEV_ADDR, lfs_pkg::CMD_BIAS_LIMIT, 16'h0040, ok);
    chk(16'(ok), 16'h0001, "limit write acked");
    bias = 7'h40;
    cyc(3);
    chk(status, 16'h0700, "bias at limit");
    bias = 7'h00;
    rep = 1'b0;
    for (int i = 0; i < 5; i++) begin
      b = 16'h0001 << i;
      pulse(i);
      cyc(3);
      chk(status, 16'h0120 | b, "fault latched");
      chk(16'(tx_drive), 16'h0000, "auto shutdown");
      rd_status(1'b0);
      chk(rd, (16'h0120 | b) & 16'h00ff, "low byte only");
      chk(status, 16'h0120 | b, "kept after partial read");
      toggle_en();
      rd_status(1'b1);
      chk(rd, 16'h0700 | b, "full read");
      chk(status, 16'h0700, "cleared on read");
    end
    tdone("sources");
    op_en = 1'b0;
    up_en = 1'b0;
    oc_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      pulse(i);
    end
    cyc(3);
    chk(status, 16'h0700, "detection disabled");
    op_en = 1'b1;
    up_en = 1'b1;
    oc_en = 1'b1;
    clm = 1'b0;
    pulse(1);
    pulse(2);
    cyc(3);
    chk(status, 16'h0700, "open loop");
    clm = 1'b1;
    auto_sd = 1'b0;
    pulse(3);
    cyc(3);
    chk(status, 16'h0128, "fault without shutdown");
    chk(16'(tx_drive), 16'h0001, "still driving");
    toggle_en();
    rd_status(1'b1);
    chk(status, 16'h0700, "recovered");
    // a fault that lands between snapshot and clear must survive the read
    pulse(0);
    toggle_en();
    fork
      rd_status(1'b1);
      begin
        cyc(600);
        pulse(0);
      end
    join
    chk(rd, 16'h0701, "snapshot before late fault");
    chk(status, 16'h0121, "late fault survives clear");
    toggle_en();
    rd_status(1'b1);
    chk(status, 16'h0700, "late fault cleared");
    auto_sd = 1'b1;
    tdone("gating");
    u_host.read_word(lfs_pkg::DEV_ADDR, 8'h13, 1'b1, rd, ok);
    chk(rd, 16'h0000, "unknown command");
    u_host.write_word(lfs_pkg::DEV_ADDR ^ 7'h01, lfs_pkg::CMD_BIAS_LIMIT, 16'h007f, ok);
    chk(16'(ok), 16'h0000, "foreign address");
    u_host.read_word(lfs_pkg::DEV_ADDR, lfs_pkg::CMD_BIAS_LIMIT, 1'b1, rd, ok);
    chk(16'(ok), 16'h0001, "limit read acked");
    chk(rd, 16'h0040, "limit kept");
    tdone("refused");
    rep = 1'b1;
    pulse(3);
    cyc(3);
    soft_en = 1'b0;
    cyc(3);
    chk(status, 16'h0148, "first fault");
    soft_en = 1'b1;
    cyc(10);
    pulse(1);
    cyc(3);
    chk(16'({status[7], tx_drive}), 16'h0002, "second fault");
    toggle_en();
    cyc(70);
    chk(16'({status[9], status[7], tx_drive}), 16'h0002, "locked out");
    tdone("lockout");
    finish_test();
  end
endmodule : laser_fault_status_supervisor_tb_top
